// >>> ecs_ctrl.sv
// Controller that drives an external check-bit/syndrome generator
`timescale 1ns/100ps

// Summary of operation
// - Check bus direction alternates by mode
// - Write: selects low, direction low
// - Read-flag: high, low, direction high
// - Latch: selects high, direction high
// - Syndrome out: selects high, direction low
module ecs_ctrl
(
   // Clock and reset
   input  wire logic                          ref_clk_i,
   input  wire logic                          rst_i,
   // Software register port
   input  wire logic [ecs_pkg::ADDR_W-1:0]    reg_addr_i,
   input  wire logic [ecs_pkg::REG_W-1:0]     reg_wdata_i,
   input  wire logic                          reg_wr_i,
   input  wire logic                          reg_rd_i,
   output logic      [ecs_pkg::REG_W-1:0]     reg_rdata_o,
   // Interrupt
   output logic                               irq_o,
   // Device data and mode pins
   output logic      [ecs_pkg::DATA_W-1:0]    protected_data_word_o,
   output logic                               mode_select_low_o,
   output logic                               mode_select_high_o,
   output logic                               bus_drive_select_o,
   // Device check/syndrome bus, two-way
   input  wire logic [ecs_pkg::CHECK_W-1:0]   check_syndrome_bus_i,
   output logic      [ecs_pkg::CHECK_W-1:0]   check_syndrome_bus_o,
   output logic                               check_syndrome_bus_oe_o,
   // Device error flags
   input  wire logic                          single_error_indicator_i,
   input  wire logic                          double_error_indicator_i
);
   import ecs_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   typedef enum logic [2:0] {ST_IDLE, ST_TURN, ST_WAIT, ST_DONE} ecs_state_t;

   ecs_state_t           state_ff;
   ecs_state_t           nxt_state;
   logic [CTRL_OP_W-1:0] op_ff;
   logic [DATA_W-1:0]    data_ff;
   logic [CHECK_W-1:0]   check_wr_ff;
   logic [CHECK_W-1:0]   check_rd_ff;
   logic                 single_ff;
   logic                 double_ff;
   logic [IRQ_W-1:0]     irq_stat_ff;
   logic [IRQ_W-1:0]     irq_mask_ff;
   logic [REG_W-1:0]     rdata_ff;
   logic                 sel_low_ff;
   logic                 sel_high_ff;
   logic                 dir_ff;
   logic                 oe_ff;
   logic [CHECK_W-1:0]   check_sync;
   logic [1:0]           flag_sync;
   logic                 timer_done;
   logic                 op_legal;
   logic                 start_req;
   logic                 flags_valid;
   logic                 nxt_low;
   logic                 nxt_high;
   logic                 nxt_dir;
   logic [IRQ_W-1:0]     irq_set;

   // ****************************************************************
   // Pin input synchronisers and settle timer
   // ****************************************************************
   ecs_sync #(.WIDTH(CHECK_W)) u_sync_check (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   (check_syndrome_bus_i),
      .sync_o    (check_sync)
   );

   ecs_sync #(.WIDTH(2)) u_sync_flag (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   ({double_error_indicator_i, single_error_indicator_i}),
      .sync_o    (flag_sync)
   );

   ecs_timer #(.COUNT(WAIT_CYC), .CNT_W(4)) u_timer (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .start_i   (state_ff == ST_TURN),
      .done_o    (timer_done)
   );

   // ****************************************************************
   // Operation decode
   // ****************************************************************
   always_comb begin
      op_legal = 1'b1;
      nxt_low  = 1'b0;
      nxt_high = 1'b1;
      nxt_dir  = 1'b1;
      unique case (reg_wdata_i[CTRL_OP_LSB +: CTRL_OP_W])
         OP_GEN_CHECK: begin
            nxt_high = 1'b0;
            nxt_dir  = 1'b0;
         end
         OP_READ_FLAG: begin
            nxt_dir = 1'b1;
         end
         // latch check bits, also diagnostic word in
         OP_LATCH: begin
            nxt_low = 1'b1;
         end
         OP_SYNDROME: begin
            nxt_low = 1'b1;
            nxt_dir = 1'b0;
         end
         OP_DIAG_OUT: begin
            nxt_low  = 1'b1;
            nxt_high = 1'b0;
            nxt_dir  = 1'b0;
         end
         default: begin
            op_legal = 1'b0;
         end
      endcase
   end

   // Busy or illegal starts are dropped; software polls the busy bit
   assign start_req = reg_wr_i && (reg_addr_i == ADDR_CTRL) && reg_wdata_i[CTRL_START]
                      && op_legal && (state_ff == ST_IDLE);

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (start_req) begin
               nxt_state = ST_TURN;
            end
         end
         ST_TURN: begin
            nxt_state = ST_WAIT;
         end
         ST_WAIT: begin
            if (timer_done) begin
               nxt_state = ST_DONE;
            end
         end
         ST_DONE: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_ff <= OP_READ_FLAG;
      end else if (start_req) begin
         op_ff <= reg_wdata_i[CTRL_OP_LSB +: CTRL_OP_W];
      end
   end

   // ****************************************************************
   // Mode pins; idle parks the device with its bus released
   // ****************************************************************
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_low_ff  <= 1'b0;
         sel_high_ff <= 1'b1;
         dir_ff      <= 1'b1;
      end else if (start_req) begin
         sel_low_ff  <= nxt_low;
         sel_high_ff <= nxt_high;
         dir_ff      <= nxt_dir;
      end else if (state_ff == ST_DONE) begin
         sel_low_ff  <= 1'b0;
         sel_high_ff <= 1'b1;
         dir_ff      <= 1'b1;
      end
   end

   // ****************************************************************
   // Check bus drive; one dead cycle on each turn avoids contention
   // ****************************************************************
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         oe_ff <= 1'b0;
      end else if (state_ff == ST_TURN) begin
         oe_ff <= dir_ff;
      end else if (state_ff != ST_WAIT) begin
         oe_ff <= 1'b0;
      end
   end

   // ****************************************************************
   // Result capture
   // ****************************************************************
   // Flags mean nothing during check generation, where both sit high
   assign flags_valid = (op_ff != OP_GEN_CHECK);

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         check_rd_ff <= CHECK_RST;
         single_ff   <= 1'b0;
         double_ff   <= 1'b0;
      end else if ((state_ff == ST_WAIT) && timer_done) begin
         // generated, syndrome or latched bits read back
         check_rd_ff <= check_sync;
         single_ff   <= flags_valid & flag_sync[0];
         double_ff   <= flags_valid & flag_sync[1];
      end
   end

   // ****************************************************************
   // Software registers
   // ****************************************************************
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         data_ff     <= DATA_RST;
         check_wr_ff <= CHECK_RST;
         irq_mask_ff <= IRQ_RST;
      end else if (reg_wr_i) begin
         if (reg_addr_i == ADDR_DATA && state_ff == ST_IDLE) begin
            data_ff <= reg_wdata_i[DATA_W-1:0];
         end
         if (reg_addr_i == ADDR_CHECK_WR && state_ff == ST_IDLE) begin
            check_wr_ff <= reg_wdata_i[CHECK_W-1:0];
         end
         if (reg_addr_i == ADDR_IRQ_MASK) begin
            irq_mask_ff <= reg_wdata_i[IRQ_W-1:0];
         end
      end
   end

   // ****************************************************************
   // Interrupt status; a new event wins over a clear
   // ****************************************************************
   always_comb begin
      irq_set             = IRQ_RST;
      irq_set[IRQ_DONE]   = (state_ff == ST_DONE);
      irq_set[IRQ_SINGLE] = (state_ff == ST_DONE) & single_ff;
      irq_set[IRQ_DOUBLE] = (state_ff == ST_DONE) & double_ff;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_stat_ff <= IRQ_RST;
      end else if (reg_wr_i && reg_addr_i == ADDR_IRQ_STAT) begin
         irq_stat_ff <= (irq_stat_ff & ~reg_wdata_i[IRQ_W-1:0]) | irq_set;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_set;
      end
   end

   // ****************************************************************
   // Read port: data stand for one cycle only
   // ****************************************************************
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_ff <= '0;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            ADDR_CTRL:     rdata_ff <= REG_W'(op_ff);
            ADDR_DATA:     rdata_ff <= REG_W'(data_ff);
            ADDR_CHECK_WR: rdata_ff <= REG_W'(check_wr_ff);
            ADDR_STATUS:   rdata_ff <= REG_W'({double_ff, single_ff, state_ff != ST_IDLE});
            ADDR_CHECK_RD: rdata_ff <= REG_W'(check_rd_ff);
            ADDR_IRQ_STAT: rdata_ff <= REG_W'(irq_stat_ff);
            ADDR_IRQ_MASK: rdata_ff <= REG_W'(irq_mask_ff);
            default:       rdata_ff <= '0;
         endcase
      end else begin
         rdata_ff <= '0;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign reg_rdata_o             = rdata_ff;
   assign irq_o                   = |(irq_stat_ff & irq_mask_ff);
   assign protected_data_word_o   = data_ff;
   assign mode_select_low_o       = sel_low_ff;
   assign mode_select_high_o      = sel_high_ff;
   assign bus_drive_select_o      = dir_ff;
   assign check_syndrome_bus_o    = check_wr_ff;
   assign check_syndrome_bus_oe_o = oe_ff;
endmodule // ecs_ctrl

// >>> ecs_ctrl_assertions.sv
// Port checker for the check-bit generator controller
`timescale 1ns/100ps
module ecs_ctrl_assertions (
   // Clock and reset
   input wire logic                       ref_clk_i,
   input wire logic                       rst_i,
   // Register port
   input wire logic [ecs_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [ecs_pkg::REG_W-1:0]  reg_wdata_i,
   input wire logic                       reg_wr_i,
   input wire logic                       irq_o,
   // Device pins
   input wire logic [ecs_pkg::DATA_W-1:0] protected_data_word_o,
   input wire logic                       mode_select_low_o,
   input wire logic                       mode_select_high_o,
   input wire logic                       bus_drive_select_o,
   input wire logic                       check_syndrome_bus_oe_o
);
   import ecs_pkg::*;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   logic [3:0] cnt_ff;
   logic [2:0] op_ff;
   logic [2:0] pins;
   logic       start;
   logic       oe;
   assign oe = check_syndrome_bus_oe_o;
   assign pins = {mode_select_high_o, mode_select_low_o, bus_drive_select_o};
   assign start = reg_wr_i && reg_addr_i == ADDR_CTRL && reg_wdata_i[CTRL_START]
                  && reg_wdata_i[2:0] < 3'h5 && cnt_ff == 4'h0;
   function automatic logic [2:0] exp_pins(logic [2:0] op);
      case (op)
         OP_GEN_CHECK: return 3'h0;
         OP_LATCH: return 3'h7;
         OP_SYNDROME: return 3'h6;
         OP_DIAG_OUT: return 3'h2;
         default: return 3'h5;
      endcase
   endfunction
   // Own busy window, eight cycles after a start that was accepted
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff <= 4'h0;
         op_ff <= 3'h0;
      end else if (start) begin
         cnt_ff <= 4'h8;
         op_ff <= reg_wdata_i[2:0];
      end else if (cnt_ff != 4'h0) begin
         cnt_ff <= cnt_ff - 4'h1;
      end
   end
   // ****************************************************************
   // Properties
   // ****************************************************************
   property p_write_pins;
      start && reg_wdata_i[2:0] == OP_GEN_CHECK |=> pins == 3'h0 && !oe;
   endproperty
   a_write_pins: assert property (p_write_pins) else $error("write mode pins wrong");
   property p_op_pins;
      cnt_ff != 4'h0 |-> pins == exp_pins(op_ff);
   endproperty
   a_op_pins: assert property (p_op_pins) else $error("mode pins wrong in op");
   property p_park;
      cnt_ff == 4'h1 |=> pins == 3'h5 && !oe;
   endproperty
   a_park: assert property (p_park) else $error("pins not parked after op");
   property p_idle_stable;
      cnt_ff == 4'h0 && !start |=> $stable(pins) && !oe;
   endproperty
   a_idle_stable: assert property (p_idle_stable) else $error("pins moved while idle");
   property p_oe_dir;
      oe |-> bus_drive_select_o && mode_select_high_o && cnt_ff != 4'h0;
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("host drives against device");
   property p_oe_fall;
      $fell(bus_drive_select_o) |-> !$past(oe);
   endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("bus not released before turn");
   property p_oe_rise;
      $rose(oe) |-> $past(bus_drive_select_o);
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("host drove too early");
   property p_data_word;
      reg_wr_i && reg_addr_i == ADDR_DATA |=>
         protected_data_word_o == ($past(cnt_ff) == 4'h0 ? $past(reg_wdata_i)
                                                          : $past(protected_data_word_o));
   endproperty
   a_data_word: assert property (p_data_word) else $error("data word pins wrong");
   property p_irq_mask;
      reg_wr_i && reg_addr_i == ADDR_IRQ_MASK && reg_wdata_i[2:0] == 3'h0 |=> !irq_o;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
   property p_irq_hold;
      irq_o && !reg_wr_i |=> irq_o;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by itself");
endmodule // ecs_ctrl_assertions

bind ecs_ctrl ecs_ctrl_assertions u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .irq_o(irq_o),
   .protected_data_word_o(protected_data_word_o), .mode_select_low_o(mode_select_low_o),
   .mode_select_high_o(mode_select_high_o), .bus_drive_select_o(bus_drive_select_o),
   .check_syndrome_bus_oe_o(check_syndrome_bus_oe_o));

// >>> ecs_dev_model.sv
// Behavioural check-bit and syndrome generator facing the controller
`timescale 1ns/100ps
module ecs_dev_model (
   // Clock, for the floating-bus pattern and the check-bit latch
   input  wire logic                         ref_clk_i,
   // Pins from the controller
   input  wire logic [ecs_pkg::DATA_W-1:0]   data_i,
   input  wire logic                         sel_low_i,
   input  wire logic                         sel_high_i,
   input  wire logic                         drive_sel_i,
   input  wire logic [ecs_pkg::CHECK_W-1:0]  host_val_i,
   input  wire logic                         host_oe_i,
   // Resolved bus and flags
   output logic      [ecs_pkg::CHECK_W-1:0]  bus_o,
   output logic                              single_o,
   output logic                              double_o
);
   import ecs_pkg::*;
   logic [CHECK_W-1:0] gen;
   logic [CHECK_W-1:0] syn;
   logic [CHECK_W-1:0] dev_val;
   logic [CHECK_W-1:0] latch_ff;
   logic [CHECK_W-1:0] last_ff = 7'h00;
   // weight-three data columns keep single errors odd and unique
   function automatic logic [CHECK_W-1:0] chk_f(logic [DATA_W-1:0] d);
      logic [CHECK_W-1:0] c;
      int k;
      c = '0;
      k = 0;
      for (int v = 7; v < 128; v++) begin
         if ($countones(v) == 3 && k < DATA_W) begin
            if (d[k]) c ^= v[CHECK_W-1:0];
            k++;
         end
      end
      return c;
   endfunction
   assign gen = chk_f(data_i);
   assign syn = gen ^ (drive_sel_i ? bus_o : latch_ff);
   // value driven while direction is low
   always_comb begin
      case ({sel_high_i, sel_low_i})
         2'b00: dev_val = gen;
         2'b01: dev_val = latch_ff;
         default: dev_val = syn;
      endcase
   end
   // released when direction high; an idle bus shows the inverse of its last value
   assign bus_o = host_oe_i ? host_val_i : (!drive_sel_i ? dev_val : ~last_ff);
   always @(posedge ref_clk_i) begin
      if (host_oe_i || !drive_sel_i) last_ff <= bus_o;
   end
   // latch takes only a driven bus
   always @(posedge ref_clk_i) begin
      if (sel_high_i && sel_low_i && drive_sel_i && host_oe_i) latch_ff <= bus_o;
   end
   // flags held high in write mode
   assign single_o = (!sel_high_i && !sel_low_i) ? 1'b1 : ^syn;
   assign double_o = (!sel_high_i && !sel_low_i) ? 1'b1 : (syn != '0 && !(^syn));
endmodule // ecs_dev_model

// >>> ecs_pkg.sv
// Constants and register map of the check-bit generator controller
package ecs_pkg;
   // ****************************************************************
   // Bus widths
   // ****************************************************************
   localparam int DATA_W   = 32;
   localparam int CHECK_W  = 7;
   localparam int ADDR_W   = 4;
   localparam int REG_W    = 32;

   // ****************************************************************
   // Register addresses (word addresses on the plain port)
   // ****************************************************************
   localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_DATA     = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_CHECK_WR = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_CHECK_RD = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h6;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_OP_LSB   = 0;
   localparam int CTRL_OP_W     = 3;
   localparam int CTRL_START    = 8;
   localparam int STAT_BUSY     = 0;
   localparam int STAT_SINGLE   = 1;
   localparam int STAT_DOUBLE   = 2;
   localparam int IRQ_DONE      = 0;
   localparam int IRQ_SINGLE    = 1;
   localparam int IRQ_DOUBLE    = 2;
   localparam int IRQ_W         = 3;

   // ****************************************************************
   // Operation codes written to the control register
   // ****************************************************************
   localparam logic [CTRL_OP_W-1:0] OP_GEN_CHECK  = 3'h0;
   localparam logic [CTRL_OP_W-1:0] OP_READ_FLAG  = 3'h1;
   localparam logic [CTRL_OP_W-1:0] OP_LATCH      = 3'h2;
   localparam logic [CTRL_OP_W-1:0] OP_SYNDROME   = 3'h3;
   localparam logic [CTRL_OP_W-1:0] OP_DIAG_OUT   = 3'h4;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [DATA_W-1:0]  DATA_RST  = 32'h0000_0000;
   localparam logic [CHECK_W-1:0] CHECK_RST = 7'h00;
   localparam logic [IRQ_W-1:0]   IRQ_RST   = 3'h0;

   // ****************************************************************
   // Timing: worst device delay to a flag, rounded up to cycles
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int SETTLE_NS     = 26;
   localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_STAGES   = 2;
   localparam int WAIT_CYC      = SETTLE_CYC + SYNC_STAGES + 1;
endpackage : ecs_pkg

// >>> ecs_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ecs_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   // Data
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   initial begin
      if (WIDTH < 1) begin
         $error("ecs_sync: WIDTH must be at least 1");
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;
endmodule // ecs_sync

// >>> ecs_timer.sv
// One-shot settle timer: done pulses COUNT cycles after start
`timescale 1ns/100ps
module ecs_timer #(
   parameter int COUNT = 6,
   parameter int CNT_W = 4
) (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   // Control
   input  wire logic start_i,
   output logic      done_o
);
   logic [CNT_W-1:0] cnt_ff;

   initial begin
      if (COUNT < 1 || COUNT >= (1 << CNT_W)) begin
         $error("ecs_timer: COUNT does not fit CNT_W");
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff <= '0;
      end else if (start_i) begin
         cnt_ff <= CNT_W'(COUNT);
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   assign done_o = (cnt_ff == CNT_W'(1));
endmodule // ecs_timer

// >>> test_ecs_ctrl.sv
// Self-checking bench for the check-bit generator controller
`timescale 1ns/100ps
module test_ecs_ctrl;
   import ecs_pkg::*;
   logic               ref_clk_i = 1'b0;
   logic               rst_i = 1'b1;
   logic [ADDR_W-1:0]  addr = '0;
   logic [REG_W-1:0]   wdata = '0;
   logic               wr = 1'b0;
   logic               rd = 1'b0;
   logic [REG_W-1:0]   rdata;
   logic               irq, ml, mh, dir, hoe, single_error_indicator, def;
   logic [DATA_W-1:0]  dw;
   logic [CHECK_W-1:0] hb, bus;
   logic [REG_W-1:0]   r;
   int                 fail_count = 0;
   int                 total_checks = 0;
   localparam logic [DATA_W-1:0] D0 = 32'hA5C3_0F12;
   initial forever #5 ref_clk_i = ~ref_clk_i;
   ecs_ctrl uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq),
      .protected_data_word_o(dw), .mode_select_low_o(ml), .mode_select_high_o(mh),
      .bus_drive_select_o(dir), .check_syndrome_bus_i(bus), .check_syndrome_bus_o(hb),
      .check_syndrome_bus_oe_o(hoe), .single_error_indicator_i(single_error_indicator),
      .double_error_indicator_i(def));
   ecs_dev_model dev (.ref_clk_i(ref_clk_i), .data_i(dw), .sel_low_i(ml), .sel_high_i(mh),
      .drive_sel_i(dir), .host_val_i(hb), .host_oe_i(hoe), .bus_o(bus), .single_o(single_error_indicator),
      .double_o(def));
   // ****************************************************************
   // Bus and report tasks
   // ****************************************************************
   task automatic test_done();
      if (fail_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [REG_W-1:0] got, input logic [REG_W-1:0] want, input string s);
      total_checks++;
      if (got !== want) begin
         fail_count++;
         $display("mismatch at %0t: %s", $time, s);
      end
   endtask
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
      @(posedge ref_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] want, input string s);
      @(posedge ref_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk_i);
      rd <= 1'b0;
      #1 r = rdata;
      if (want !== 32'hFFFF_FFFF) cmp(r, want, s);
   endtask
   // Polls status under a bound; a hang ends the run
   task automatic run_op(input logic [2:0] op);
      wr_reg(ADDR_CTRL, 32'h0000_0100 | {29'h0, op});
      for (int i = 0; i < 40; i++) begin
         rd_chk(ADDR_STATUS, 32'hFFFF_FFFF, "");
         if (r[STAT_BUSY] === 1'b0) return;
      end
      cmp(32'h0, 32'h1, "operation never finished");
      test_done();
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      #1 cmp({28'h0, mh, ml, dir, hoe}, 32'h0000_000A, "parked pins");
      for (int a = 0; a < 8; a++) begin
         rd_chk(a[ADDR_W-1:0], (a == 0) ? {29'h0, OP_READ_FLAG} : 32'h0, "reset value");
      end
   endtask
   task automatic t_gen();
      wr_reg(ADDR_DATA, D0);
      run_op(OP_GEN_CHECK);
      rd_chk(ADDR_CHECK_RD, {25'h0, dev.chk_f(D0)}, "generated check bits");
      rd_chk(ADDR_STATUS, 32'h0, "flags in write mode");
      rd_chk(ADDR_IRQ_STAT, 32'h1, "done event");
      wr_reg(ADDR_IRQ_STAT, 32'h7);
   endtask
   task automatic t_flag();
      logic [DATA_W-1:0]  df [4] = '{32'h0, 32'h0, 32'h0, 32'h0000_0200};
      logic [CHECK_W-1:0] cf [4] = '{7'h00, 7'h04, 7'h21, 7'h00};
      logic [2:0]         ef [4] = '{3'h0, 3'h2, 3'h4, 3'h2};
      for (int i = 0; i < 4; i++) begin
         wr_reg(ADDR_DATA, D0 ^ df[i]);
         wr_reg(ADDR_CHECK_WR, {25'h0, dev.chk_f(D0) ^ cf[i]});
         run_op(OP_READ_FLAG);
         rd_chk(ADDR_STATUS, {29'h0, ef[i]}, "read and flag status");
         rd_chk(ADDR_IRQ_STAT, {29'h0, ef[i] | 3'h1}, "error events");
         wr_reg(ADDR_IRQ_STAT, 32'h7);
      end
   endtask
   task automatic t_latch();
      wr_reg(ADDR_DATA, D0);
      wr_reg(ADDR_CHECK_WR, {25'h0, dev.chk_f(D0) ^ 7'h08});
      run_op(OP_LATCH);
      run_op(OP_SYNDROME);
      rd_chk(ADDR_CHECK_RD, 32'h0000_0008, "syndrome on bus");
      rd_chk(ADDR_STATUS, 32'h0000_0002, "error from latched bits");
      run_op(OP_DIAG_OUT);
      rd_chk(ADDR_CHECK_RD, {25'h0, dev.chk_f(D0) ^ 7'h08}, "latched bits out");
      wr_reg(ADDR_IRQ_STAT, 32'h7);
   endtask
   task automatic t_irq();
      run_op(OP_GEN_CHECK);
      cmp({31'h0, irq}, 32'h0, "masked event");
      wr_reg(ADDR_IRQ_MASK, 32'h1);
      #1 cmp({31'h0, irq}, 32'h1, "unmasked event");
      rd_chk(ADDR_IRQ_MASK, 32'h1, "mask readback");
      wr_reg(ADDR_IRQ_STAT, 32'h1);
      #1 cmp({31'h0, irq}, 32'h0, "cleared event");
      wr_reg(ADDR_IRQ_MASK, 32'h0);
   endtask
   // Busy, illegal and unmapped requests are all ignored
   task automatic t_refuse();
      wr_reg(ADDR_DATA, D0);
      wr_reg(ADDR_CTRL, 32'h0000_0100);
      wr_reg(ADDR_DATA, ~D0);
      wr_reg(ADDR_CTRL, 32'h0000_0103);
      run_op(3'h5);
      run_op(3'h5);
      rd_chk(ADDR_CTRL, 32'h0, "last op kept");
      rd_chk(ADDR_DATA, D0, "data kept while busy");
      wr_reg(4'h7, 32'hFFFF_FFFE);
      rd_chk(4'h7, 32'h0, "unmapped address");
      wr_reg(ADDR_IRQ_STAT, 32'h7);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_gen();
      t_flag();
      t_latch();
      t_irq();
      t_refuse();
      test_done();
   end
endmodule // test_ecs_ctrl
